// [src/iocs_pkg.sv]
// Package of codes, counts and reset values for the I/O command interpreter
`default_nettype none
package iocs_pkg;
  localparam int IOCS_PORTS = 3;
  localparam int IOCS_PINS = 24;
  // Command characters
  localparam logic [7:0] IOCS_CMD_WR_A = 8'h41;
  localparam logic [7:0] IOCS_CMD_RD_A = 8'h61;
  localparam logic [7:0] IOCS_CMD_DIR = 8'h21;
  localparam logic [7:0] IOCS_CMD_SPI_A = 8'h53;
  localparam logic [7:0] IOCS_CMD_CONV = 8'h4A;
  localparam logic [7:0] IOCS_CMD_TEMP = 8'h4B;
  localparam logic [7:0] IOCS_CMD_MODE1 = 8'h31;
  localparam logic [7:0] IOCS_CMD_MODE2 = 8'h32;
  // Status characters
  localparam logic [7:0] IOCS_ST_GOOD = 8'h47;
  localparam logic [7:0] IOCS_ST_CRC = 8'h43;
  localparam logic [7:0] IOCS_ST_NONE = 8'h4E;
  localparam logic [7:0] IOCS_ST_BADPIN = 8'h45;
  localparam logic [7:0] IOCS_ST_SHORT = 8'h53;
  // Sensor result codes from the one-wire engine
  localparam logic [1:0] IOCS_OW_GOOD = 2'h0;
  localparam logic [1:0] IOCS_OW_CRC = 2'h1;
  localparam logic [1:0] IOCS_OW_NONE = 2'h2;
  localparam logic [1:0] IOCS_OW_SHORT = 2'h3;
  // Reset values: all pins input, outputs low
  localparam logic [7:0] IOCS_DIR_RESET = 8'hFF;
  localparam logic [7:0] IOCS_OUT_RESET = 8'h00;
  // SPI half period
  localparam int IOCS_CLK_HZ = 10_000_000;
  localparam int IOCS_SPI_HALF_NS = 1000;
  localparam int IOCS_SPI_HALF_CYC =
    (IOCS_SPI_HALF_NS * (IOCS_CLK_HZ / 1_000_000) + 999) / 1000;
  // Bit positions of the SPI pins within a port
  localparam int IOCS_SCK_BIT = 0;
  localparam int IOCS_MOSI_BIT = 1;
  localparam int IOCS_MISO_BIT = 2;
endpackage
`default_nettype wire

// [src/iocs_spi.sv]
// Bit-banged SPI byte exchange engine, MSB first
`default_nettype none
module iocs_spi
  import iocs_pkg::*;
#(
  parameter int HALF_CYC = iocs_pkg::IOCS_SPI_HALF_CYC
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic [7:0] i_data,
  input wire logic i_idle,
  input wire logic i_miso,
  output logic o_sck,
  output logic o_mosi,
  output logic o_busy,
  output logic o_done,
  output logic [7:0] o_rx
);
  import iocs_pkg::*;
  // Half period must fit the 8-bit timer
  if (HALF_CYC < 1 || HALF_CYC > 256) begin : g_bad_half
    $error("HALF_CYC out of range");
  end
  typedef struct packed {
    logic busy;
    logic phase;
    logic [2:0] bit_n;
    logic [7:0] tmr;
    logic [7:0] tx;
    logic [7:0] rx;
    logic sck;
    logic done;
  } iocs_spi_s;
  iocs_spi_s st_reg, st_next;
  // Next state: idle-level half, then leading edge samples
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (!st_reg.busy) begin
      st_next.sck = i_idle;
      if (i_start) begin
        st_next.busy = 1'b1;
        st_next.tx = i_data;
        st_next.bit_n = 3'd7;
        st_next.phase = 1'b0;
        st_next.tmr = 8'(HALF_CYC - 1);
      end
    end else if (st_reg.tmr != 8'h00) begin
      st_next.tmr = st_reg.tmr - 8'h01;
    end else begin
      st_next.tmr = 8'(HALF_CYC - 1);
      st_next.phase = ~st_reg.phase;
      if (!st_reg.phase) begin
        st_next.sck = ~i_idle; // Leading edge, sample
        st_next.rx = {st_reg.rx[6:0], i_miso};
      end else begin
        st_next.sck = i_idle;
        st_next.tx = {st_reg.tx[6:0], 1'b0};
        st_next.bit_n = st_reg.bit_n - 3'd1;
        if (st_reg.bit_n == 3'd0) begin
          st_next.busy = 1'b0;
          st_next.done = 1'b1;
        end
      end
    end
  end
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign o_sck = st_reg.sck;
  assign o_mosi = st_reg.tx[7]; // Changes only at idle level
  assign o_busy = st_reg.busy;
  assign o_done = st_reg.done;
  assign o_rx = st_reg.rx;
endmodule
`default_nettype wire

// [src/iocs_top.sv]
// Command interpreter for a 24-pin three-port I/O module
`default_nettype none
module iocs_top
  import iocs_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_valid,
  output logic o_rx_ready,
  output logic [7:0] o_tx_data,
  output logic o_tx_valid,
  input wire logic i_tx_ready,
  input wire logic [iocs_pkg::IOCS_PINS-1:0] i_pin,
  output logic [iocs_pkg::IOCS_PINS-1:0] o_pin,
  output logic [iocs_pkg::IOCS_PINS-1:0] o_pin_oe,
  output logic o_report_mode,
  output logic o_ow_start,
  output logic o_ow_read,
  output logic [4:0] o_ow_pin,
  input wire logic i_ow_done,
  input wire logic [1:0] i_ow_result,
  input wire logic [15:0] i_ow_temp
);
  import iocs_pkg::*;
  typedef enum {
    S_CMD, S_DIRSEL, S_WDATA, S_DDATA, S_SPIDATA, S_SPIRUN,
    S_OWPIN, S_OWWAIT, S_TX
  } iocs_state_e;
  typedef struct packed {
    iocs_state_e state;
    logic [7:0] cmd;
    logic [1:0] port;
    logic [23:0] outv;
    logic [23:0] dirv;
    logic mode2;
    logic spi_on;
    logic [1:0] spi_port;
    logic [7:0] tx0;
    logic [7:0] tx1;
    logic [7:0] tx2;
    logic [1:0] tx_cnt;
    logic [2:0] rep_pend;
    logic [23:0] in_last;
    logic ow_start;
    logic ow_read;
    logic [4:0] ow_pin;
  } iocs_s;
  iocs_s st_reg, st_next;

  // Reset release through two flops
  logic [1:0] rst_sync_reg;
  logic rst_n;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // Pin inputs through two flops
  logic [23:0] pin_s1_reg, pin_s2_reg;
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
    end else begin
      pin_s1_reg <= i_pin;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // SPI engine, one shared by all ports
  logic spi_start, spi_sck, spi_mosi, spi_busy, spi_done, spi_idle;
  logic spi_miso;
  logic [7:0] spi_rx;
  assign spi_idle = st_reg.outv[{st_reg.port, 3'(IOCS_SCK_BIT)}];
  assign spi_miso =
    pin_s2_reg[{st_reg.spi_port, 3'(IOCS_MISO_BIT)}];
  iocs_spi u_spi (
    .i_clock(i_clock),
    .i_rst_n(rst_n),
    .i_start(spi_start),
    .i_data(i_rx_data),
    .i_idle(spi_idle),
    .i_miso(spi_miso),
    .o_sck(spi_sck),
    .o_mosi(spi_mosi),
    .o_busy(spi_busy),
    .o_done(spi_done),
    .o_rx(spi_rx)
  );

  // Helpers
  logic rx_take, tx_take;
  logic [7:0] port_in [IOCS_PORTS];
  logic [7:0] port_letter [IOCS_PORTS];
  logic [23:0] in_mask, changed;
  assign tx_take = o_tx_valid && i_tx_ready;
  assign in_mask = st_reg.dirv;
  assign changed = (pin_s2_reg ^ st_reg.in_last) & in_mask;
  genvar g;
  generate
    for (g = 0; g < IOCS_PORTS; g++) begin : g_port
      // Outputs read back as driven, inputs as sampled
      assign port_in[g] = (st_reg.outv[g*8 +: 8] & ~st_reg.dirv[g*8 +: 8]) |
                          (pin_s2_reg[g*8 +: 8] & st_reg.dirv[g*8 +: 8]);
      assign port_letter[g] = IOCS_CMD_RD_A + 8'(g);
    end
  endgenerate
  assign spi_start = (st_reg.state == S_SPIDATA) && i_rx_valid;
  assign rx_take = o_rx_ready && i_rx_valid;

  // Command decoding and reply sequencing
  always_comb begin
    st_next = st_reg;
    st_next.ow_start = 1'b0;
    st_next.ow_read = 1'b0;
    if (st_reg.mode2) begin
      for (int p = 0; p < IOCS_PORTS; p++) begin
        if (changed[p*8 +: 8] != 8'h00) begin
          st_next.rep_pend[p] = 1'b1;
        end
      end
      st_next.in_last = pin_s2_reg;
    end
    case (st_reg.state)
      S_CMD: begin
        if (i_rx_valid) begin
          st_next.cmd = i_rx_data; // ASCII command
          if (i_rx_data >= IOCS_CMD_WR_A &&
              i_rx_data < IOCS_CMD_WR_A + 8'd3) begin
            st_next.port = 2'(i_rx_data - IOCS_CMD_WR_A);
            st_next.state = S_WDATA;
          end else if (i_rx_data >= IOCS_CMD_RD_A &&
                       i_rx_data < IOCS_CMD_RD_A + 8'd3) begin
            st_next.port = 2'(i_rx_data - IOCS_CMD_RD_A);
            if (st_reg.mode2) begin
              st_next.tx0 = i_rx_data;
              st_next.tx1 = port_in[2'(i_rx_data - IOCS_CMD_RD_A)];
              st_next.tx_cnt = 2'd2;
            end else begin
              st_next.tx0 = port_in[2'(i_rx_data - IOCS_CMD_RD_A)];
              st_next.tx_cnt = 2'd1;
            end
            st_next.state = S_TX;
          end else if (i_rx_data == IOCS_CMD_DIR) begin
            st_next.state = S_DIRSEL;
          end else if (i_rx_data >= IOCS_CMD_SPI_A &&
                       i_rx_data < IOCS_CMD_SPI_A + 8'd3) begin
            st_next.port = 2'(i_rx_data - IOCS_CMD_SPI_A);
            st_next.state = S_SPIDATA;
          end else if (i_rx_data == IOCS_CMD_CONV ||
                       i_rx_data == IOCS_CMD_TEMP) begin
            st_next.state = S_OWPIN;
          end else if (i_rx_data == IOCS_CMD_MODE2) begin
            st_next.mode2 = 1'b1;
            st_next.in_last = pin_s2_reg;
          end else if (i_rx_data == IOCS_CMD_MODE1) begin
            st_next.mode2 = 1'b0;
            st_next.rep_pend = '0;
          end
          // Anything else is dropped here
        end else if (st_reg.mode2 && st_reg.rep_pend != 3'b000) begin
          for (int p = IOCS_PORTS - 1; p >= 0; p--) begin
            if (st_reg.rep_pend[p]) begin
              st_next.port = 2'(p);
            end
          end
          st_next.rep_pend[st_next.port] = 1'b0;
          st_next.tx0 = port_letter[st_next.port];
          st_next.tx1 = port_in[st_next.port];
          st_next.tx_cnt = 2'd2;
          st_next.state = S_TX;
        end
      end
      S_DIRSEL: begin
        if (i_rx_valid) begin
          if (i_rx_data >= IOCS_CMD_WR_A &&
              i_rx_data < IOCS_CMD_WR_A + 8'd3) begin
            st_next.port = 2'(i_rx_data - IOCS_CMD_WR_A);
            st_next.state = S_DDATA;
          end else begin
            st_next.state = S_CMD;
          end
        end
      end
      S_WDATA: begin
        if (i_rx_valid) begin
          st_next.outv[st_reg.port*8 +: 8] = i_rx_data;
          if (st_reg.mode2 &&
              st_reg.outv[st_reg.port*8 +: 8] != i_rx_data) begin
            st_next.rep_pend[st_reg.port] = 1'b1;
          end
          st_next.state = S_CMD;
        end
      end
      S_DDATA: begin
        if (i_rx_valid) begin
          st_next.dirv[st_reg.port*8 +: 8] = i_rx_data;
          st_next.state = S_CMD;
        end
      end
      S_SPIDATA: begin
        if (i_rx_valid) begin
          st_next.spi_on = 1'b1;
          st_next.spi_port = st_reg.port;
          st_next.state = S_SPIRUN;
        end
      end
      S_SPIRUN: begin
        if (spi_done) begin
          st_next.spi_on = 1'b0;
          st_next.tx0 = st_reg.cmd;
          st_next.tx1 = spi_rx;
          st_next.tx_cnt = 2'd2;
          st_next.state = S_TX;
        end
      end
      S_OWPIN: begin
        if (i_rx_valid) begin
          if (i_rx_data > 8'(IOCS_PINS - 1)) begin
            st_next.tx0 = IOCS_ST_BADPIN;
            st_next.tx1 = 8'h00;
            st_next.tx2 = 8'h00;
            st_next.tx_cnt = (st_reg.cmd == IOCS_CMD_TEMP) ? 2'd3 : 2'd1;
            st_next.state = S_TX;
          end else begin
            st_next.ow_pin = 5'(i_rx_data);
            st_next.ow_start = (st_reg.cmd == IOCS_CMD_CONV);
            st_next.ow_read = (st_reg.cmd == IOCS_CMD_TEMP);
            st_next.state = S_OWWAIT;
          end
        end
      end
      S_OWWAIT: begin
        if (i_ow_done) begin
          case (i_ow_result)
            IOCS_OW_GOOD: st_next.tx0 = IOCS_ST_GOOD;
            IOCS_OW_CRC: st_next.tx0 = IOCS_ST_CRC;
            IOCS_OW_NONE: st_next.tx0 = IOCS_ST_NONE;
            default: st_next.tx0 = IOCS_ST_SHORT;
          endcase
          st_next.tx1 = i_ow_temp[15:8];
          st_next.tx2 = i_ow_temp[7:0];
          // One status byte for convert
          st_next.tx_cnt = (st_reg.cmd == IOCS_CMD_TEMP) ? 2'd3 : 2'd1;
          st_next.state = S_TX;
        end
      end
      S_TX: begin
        if (tx_take) begin
          st_next.tx0 = st_reg.tx1;
          st_next.tx1 = st_reg.tx2;
          st_next.tx_cnt = st_reg.tx_cnt - 2'd1;
          if (st_reg.tx_cnt == 2'd1) begin
            st_next.state = S_CMD;
          end
        end
      end
      default: st_next.state = S_CMD;
    endcase
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.state <= S_CMD;
      st_reg.outv <= {3{IOCS_OUT_RESET}};
      st_reg.dirv <= {3{IOCS_DIR_RESET}};
    end else begin
      st_reg <= st_next;
    end
  end

  // Port pins, SPI overrides bits 0 and 1 of the active port
  always_comb begin
    o_pin = st_reg.outv;
    o_pin_oe = ~st_reg.dirv;
    if (st_reg.spi_on) begin
      o_pin[{st_reg.spi_port, 3'(IOCS_SCK_BIT)}] = spi_sck;
      o_pin[{st_reg.spi_port, 3'(IOCS_MOSI_BIT)}] = spi_mosi;
    end
  end

  // Byte stream handshake; no command taken mid reply
  assign o_rx_ready = (st_reg.state != S_TX) &&
                      (st_reg.state != S_SPIRUN) &&
                      (st_reg.state != S_OWWAIT);
  assign o_tx_valid = (st_reg.state == S_TX);
  assign o_tx_data = st_reg.tx0;
  assign o_report_mode = st_reg.mode2;
  assign o_ow_start = st_reg.ow_start;
  assign o_ow_read = st_reg.ow_read;
  assign o_ow_pin = st_reg.ow_pin;

  // Checks
  a_read_prefix: assert property (@(posedge i_clock) disable iff (!rst_n)
    st_reg.state == S_CMD && rx_take && st_reg.mode2 &&
    i_rx_data == IOCS_CMD_RD_A |=> o_tx_valid && o_tx_data == IOCS_CMD_RD_A)
    else $error("read reply lacks letter");
  a_spi_echo: assert property (@(posedge i_clock) disable iff (!rst_n)
    st_reg.state == S_SPIRUN && spi_done |=>
    o_tx_valid && o_tx_data == st_reg.cmd)
    else $error("spi reply lacks command");
  a_bad_pin: assert property (@(posedge i_clock) disable iff (!rst_n)
    st_reg.state == S_OWPIN && rx_take && i_rx_data > 8'd23 |=>
    o_tx_data == IOCS_ST_BADPIN)
    else $error("bad pin not E");
  a_mode_enter: assert property (@(posedge i_clock) disable iff (!rst_n)
    st_reg.state == S_CMD && rx_take && i_rx_data == IOCS_CMD_MODE2
    |=> o_report_mode)
    else $error("mode 2 not entered");
  a_no_take_tx: assert property (@(posedge i_clock) disable iff (!rst_n)
    o_tx_valid |-> !o_rx_ready)
    else $error("command taken during reply");
  a_sck_idle: assert property (@(posedge i_clock) disable iff (!rst_n)
    $rose(st_reg.spi_on) |=> o_pin[{st_reg.spi_port, 3'd0}] == spi_idle)
    else $error("clock not at idle level");
  a_temp_len: assert property (@(posedge i_clock) disable iff (!rst_n)
    st_reg.state == S_OWWAIT && i_ow_done && st_reg.cmd == IOCS_CMD_TEMP
    |=> st_reg.tx_cnt == 2'd3)
    else $error("temp reply not 3 bytes");
  a_write_rep: assert property (@(posedge i_clock) disable iff (!rst_n)
    st_reg.state == S_WDATA && rx_take && st_reg.mode2 &&
    st_reg.outv[st_reg.port*8 +: 8] != i_rx_data |=>
    st_reg.rep_pend != 3'b000 || o_tx_valid)
    else $error("write change not reported");
  c_spi: cover property (@(posedge i_clock) spi_done);
  c_report: cover property (@(posedge i_clock)
    st_reg.mode2 && o_tx_valid && st_reg.tx_cnt == 2'd2);
  c_temp: cover property (@(posedge i_clock)
    st_reg.state == S_OWWAIT && i_ow_done);
endmodule
`default_nettype wire

// [sim/iocs_partner.sv]
// Bench models of the SPI peripheral and the one-wire engine
`default_nettype none
module iocs_spi_dev (
  input wire logic i_sck,
  input wire logic i_mosi,
  input wire logic i_sel_n,
  input wire logic i_idle,
  input wire logic i_load,
  input wire logic [7:0] i_tx,
  output logic o_miso,
  output logic [7:0] o_got
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] shift_reg;
  initial begin
    shift_reg = 8'h00;
    o_got = 8'h00;
  end
  // Fresh byte to answer with, MSB on the line first
  always @(posedge i_load) shift_reg = i_tx;
  // Leading edge samples, trailing edge moves to the next bit
  always @(i_sck) begin
    if (!i_sel_n && i_sck !== i_idle) begin
      o_got = {o_got[6:0], i_mosi};
    end else if (!i_sel_n) begin
      shift_reg = {shift_reg[6:0], 1'b0};
    end
  end
  // Deselected line shows the inverse, never a stale value
  assign o_miso = i_sel_n ? ~shift_reg[7] : shift_reg[7];
endmodule

module iocs_ow_dev (
  input wire logic i_clock,
  input wire logic i_start,
  input wire logic i_read,
  output logic o_done
);
  timeunit 1ns;
  timeprecision 100ps;
  int wait_cnt = 0;
  initial o_done = 1'b0;
  // Answers every request after a fixed conversion delay
  always @(posedge i_clock) begin
    o_done <= 1'b0;
    if (i_start || i_read) begin
      wait_cnt <= 12;
    end else if (wait_cnt != 0) begin
      wait_cnt <= wait_cnt - 1;
      if (wait_cnt == 1) o_done <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// [sim/io_command_spi_temp_tb.sv]
// Self-checking bench of the I/O command interpreter
`default_nettype none
module io_command_spi_temp_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import iocs_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] rx_d = 8'h00;
  logic rx_v = 1'b0;
  logic tx_rdy = 1'b0;
  logic [23:0] ext = 24'h00_0009;
  logic idle = 1'b0;
  logic load = 1'b0;
  logic [7:0] tx_byte = 8'h00;
  logic [1:0] ow_res = 2'h0;
  logic [15:0] ow_temp = 16'h0000;
  logic rx_rdy, tx_v, rep, ow_st, ow_rd, ow_done, miso;
  logic [7:0] tx_d, got;
  logic [4:0] ow_pin;
  logic [23:0] pin_in, pin_out, pin_oe, extm;
  logic [7:0] dir_m [3] = '{8'hFF, 8'hFF, 8'hFF};
  logic [7:0] wr_m [3] = '{8'h00, 8'h00, 8'h00};
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  int ow_starts = 0;
  int ow_reads = 0;
  // Wire level from both drivers of every pin
  assign extm = {ext[23:3], miso, ext[1:0]};
  assign pin_in = (pin_out & pin_oe) | (extm & ~pin_oe);

  iocs_top DUT (
    .i_clock(clock), .i_nrst(nrst), .i_rx_data(rx_d), .i_rx_valid(rx_v),
    .o_rx_ready(rx_rdy), .o_tx_data(tx_d), .o_tx_valid(tx_v),
    .i_tx_ready(tx_rdy), .i_pin(pin_in), .o_pin(pin_out),
    .o_pin_oe(pin_oe), .o_report_mode(rep), .o_ow_start(ow_st),
    .o_ow_read(ow_rd), .o_ow_pin(ow_pin), .i_ow_done(ow_done),
    .i_ow_result(ow_res), .i_ow_temp(ow_temp)
  );
  iocs_spi_dev spi_dev (
    .i_sck(pin_in[0]), .i_mosi(pin_in[1]), .i_sel_n(pin_in[3]),
    .i_idle(idle), .i_load(load), .i_tx(tx_byte), .o_miso(miso),
    .o_got(got)
  );
  iocs_ow_dev ow_dev (
    .i_clock(clock), .i_start(ow_st), .i_read(ow_rd), .o_done(ow_done)
  );

  // Clock and hang guard
  initial begin
    forever #50 clock = ~clock;
  end
  // Count the one-cycle sensor request pulses
  always @(posedge clock) begin
    if (ow_st === 1'b1) ow_starts++;
    if (ow_rd === 1'b1) ow_reads++;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      finish_test();
    end
  end

  task finish_test;
    begin
      $display("checked %0d failed %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask

  task chk(input logic [23:0] g, input logic [23:0] e);
    begin
      samples_checked++;
      if (g !== e) begin
        failures++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask

  // Port level as the host should read it
  function automatic logic [7:0] lvl(input int p);
    return (wr_m[p] & ~dir_m[p]) | (extm[8*p +: 8] & dir_m[p]);
  endfunction

  // Offer one byte and hold it until taken
  task send(input logic [7:0] b);
    int n;
    begin
      n = 0;
      rx_d = b;
      rx_v = 1'b1;
      while (rx_rdy !== 1'b1 && n < 3000) begin
        @(posedge clock) #10;
        n++;
      end
      if (n >= 3000) chk(24'(rx_rdy), 24'h00_0001);
      @(posedge clock) #10 rx_v = 1'b0;
      @(posedge clock) #10;
    end
  endtask

  // Wait for one reply byte, judge it, then accept it
  task get(input logic [7:0] e);
    int n;
    begin
      n = 0;
      while (tx_v !== 1'b1 && n < 3000) begin
        @(posedge clock) #10;
        n++;
      end
      if (n >= 3000) chk(24'(tx_v), 24'h00_0001);
      chk(24'(rx_rdy), 24'h00_0000);
      chk(24'(tx_d), 24'(e));
      tx_rdy = 1'b1;
      @(posedge clock) #10 tx_rdy = 1'b0;
    end
  endtask

  task set_dir(input int p, input logic [7:0] v);
    begin
      send(IOCS_CMD_DIR);
      send(IOCS_CMD_WR_A + 8'(p));
      send(v);
      dir_m[p] = v;
    end
  endtask

  task wr_port(input int p, input logic [7:0] v);
    begin
      send(IOCS_CMD_WR_A + 8'(p));
      send(v);
      wr_m[p] = v;
    end
  endtask

  // Direction, write, read, reporting mode, unknown command
  task t_ports;
    begin
      set_dir(0, 8'h0F);
      chk(pin_oe, 24'h00_00F0);
      wr_port(0, 8'h30);
      send(IOCS_CMD_RD_A);
      get(lvl(0));
      send(IOCS_CMD_MODE2);
      chk(24'(rep), 24'h00_0001);
      send(IOCS_CMD_RD_A);
      get(IOCS_CMD_RD_A);
      get(lvl(0));
      wr_port(0, 8'hC0);
      get(IOCS_CMD_RD_A);
      get(lvl(0));
      ext[9] = 1'b1;
      get(IOCS_CMD_RD_A + 8'h01);
      get(lvl(1));
      send(IOCS_CMD_MODE1);
      chk(24'(rep), 24'h00_0000);
      send(8'h5A);
      send(IOCS_CMD_RD_A + 8'h02);
      get(lvl(2));
      chk(pin_oe, 24'h00_00F0);
    end
  endtask

  // One exchange on port A against the peripheral model
  task exch(input logic [7:0] mo, input logic [7:0] mi);
    begin
      tx_byte = mi;
      load = 1'b1;
      @(posedge clock) #10 load = 1'b0;
      send(IOCS_CMD_SPI_A);
      send(mo);
      chk(24'(pin_out[3]), 24'h00_0000);
      get(IOCS_CMD_SPI_A);
      get(mi);
      chk(24'(got), 24'(mo));
      chk(24'(pin_out[0]), 24'(idle));
    end
  endtask

  task t_spi;
    begin
      for (int p = 0; p < 3; p++) set_dir(p, 8'h04);
      ext[10] = 1'b1;
      ext[18] = 1'b1;
      idle = 1'b1;
      wr_port(0, 8'h01);
      exch(8'hA5, 8'h3C);
      idle = 1'b0;
      wr_port(0, 8'h00);
      exch(8'h5A, 8'hC3);
      for (int p = 1; p < 3; p++) begin
        send(IOCS_CMD_SPI_A + 8'(p));
        send(8'h00);
        get(IOCS_CMD_SPI_A + 8'(p));
        get(8'hFF);
      end
    end
  endtask

  // Every sensor status, a good convert, and bad pin numbers
  task t_temp;
    logic [7:0] st [4];
    begin
      st = '{IOCS_ST_GOOD, IOCS_ST_CRC, IOCS_ST_NONE, IOCS_ST_SHORT};
      for (int i = 0; i < 4; i++) begin
        ow_res = i[1:0];
        ow_temp = 16'h0190 + 16'(i);
        send(IOCS_CMD_TEMP);
        send(8'h05);
        chk(24'(ow_pin), 24'h00_0005);
        get(st[i]);
        get(ow_temp[15:8]);
        get(ow_temp[7:0]);
      end
      chk(24'(ow_reads), 24'h00_0004);
      ow_res = 2'h0;
      send(IOCS_CMD_CONV);
      send(8'h17);
      get(IOCS_ST_GOOD);
      chk(24'(ow_starts), 24'h00_0001);
      send(IOCS_CMD_RD_A);
      get(lvl(0));
      send(IOCS_CMD_TEMP);
      send(8'h18);
      get(IOCS_ST_BADPIN);
      get(8'h00);
      get(8'h00);
      send(IOCS_CMD_CONV);
      send(8'hFF);
      get(IOCS_ST_BADPIN);
      chk(24'(ow_starts), 24'h00_0001);
      chk(24'(ow_reads), 24'h00_0004);
    end
  endtask

  // Reset, then the scenarios in turn
  initial begin
    repeat (5) @(posedge clock);
    #10;
    chk(pin_oe, 24'h00_0000);
    nrst = 1'b1;
    repeat (4) @(posedge clock);
    #10;
    t_ports();
    t_spi();
    t_temp();
    finish_test();
  end
endmodule
`default_nettype wire
